// [logic/block_and_speed_search_restart.sv]
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "restart_regs.svh"
module block_and_speed_search_restart
	import restart_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        digital_input_function,
	input  wire logic        undervoltage_alarm,
	input  wire logic        overvoltage_alarm,
	output logic             gate_enable,
	output logic      [15:0] output_frequency,
	output logic      [15:0] output_voltage,
	output logic      [2:0]  search_phase
);
	state_s q;
	state_s d;
	logic   wr;
	logic   rd;
	logic   tick;
	logic   fault;
	logic   cause;
	logic   mapped;
	logic   [15:0] vmax;

	// Zero-wait slave, answers in the access cycle
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign pready = 1'b1;
	assign prdata = q.prdata;
	assign gate_enable = q.gate_en;
	assign output_frequency = q.fout;
	assign output_voltage = q.vout;
	assign vmax = 16'hffff;

	// Address decode; unmapped offsets raise pslverr
	always_comb begin
		unique case (paddr)
			`CTRL_OFF, `HOLD_OFF, `STARTF_OFF, `UPPERF_OFF, `SETF_OFF, `ILIM_OFF,
			`DECEL_OFF, `VREC_OFF, `IRMS_OFF, `STATUS_OFF, `FOUT_OFF, `VOUT_OFF:
				mapped = 1'b1;
			default:
				mapped = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~mapped;

	// Phase code for monitoring
	always_comb begin
		unique case (q.phase)
			ST_IDLE:   search_phase = 3'h0;
			ST_BLOCK:  search_phase = 3'h1;
			ST_HOLD:   search_phase = 3'h2;
			ST_VRAMP:  search_phase = 3'h3;
			ST_DECEL:  search_phase = 3'h4;
			ST_NORMAL: search_phase = 3'h5;
			// Illegal one-hot code shows as 7 so it never latches
			default:   search_phase = 3'h7;
		endcase
	end

	// Slow time base, rates and hold are counted in ticks
	assign tick = (q.tick_cnt == 16'(`TICK_CYCLES - 1));
	// Fault only counts while the drive runs and the feature is on
	assign fault = q.ena & (q.ua_s2 | q.oa_s2) & q.run_req;
	assign cause = q.bb_s2 | fault;

	always_comb begin
		d = q;
		// Pins pass two flops; stage one feeds only stage two
		d.bb_s1 = digital_input_function;
		d.bb_s2 = q.bb_s1;
		d.ua_s1 = undervoltage_alarm;
		d.ua_s2 = q.ua_s1;
		d.oa_s1 = overvoltage_alarm;
		d.oa_s2 = q.oa_s1;
		d.tick_cnt = tick ? 16'h0000 : q.tick_cnt + 16'h0001;

		// Register writes
		if (wr && mapped) begin
			unique case (paddr)
				`CTRL_OFF: begin
					d.ena = pwdata[`CTRL_ENA_BIT];
					d.sel = pwdata[`CTRL_SEL_LSB +: 2];
					d.run_req = pwdata[`CTRL_RUN_BIT];
				end
				`HOLD_OFF:   d.hold = pwdata;
				`STARTF_OFF: d.startf = pwdata[15:0];
				`UPPERF_OFF: d.upperf = pwdata[15:0];
				`SETF_OFF:   d.setf = pwdata[15:0];
				`ILIM_OFF:   d.ilim = pwdata[15:0];
				`DECEL_OFF:  d.decel = pwdata[15:0];
				`VREC_OFF:   d.vrec = pwdata[15:0];
				`IRMS_OFF:   d.irms = pwdata[15:0];
				default: begin
				end
			endcase
		end

		// Read data captured in setup, stable through access
		if (rd) begin
			unique case (paddr)
				`CTRL_OFF:   d.prdata = {28'h0, q.run_req, q.sel, q.ena};
				`HOLD_OFF:   d.prdata = q.hold;
				`STARTF_OFF: d.prdata = {16'h0, q.startf};
				`UPPERF_OFF: d.prdata = {16'h0, q.upperf};
				`SETF_OFF:   d.prdata = {16'h0, q.setf};
				`ILIM_OFF:   d.prdata = {16'h0, q.ilim};
				`DECEL_OFF:  d.prdata = {16'h0, q.decel};
				`VREC_OFF:   d.prdata = {16'h0, q.vrec};
				`IRMS_OFF:   d.prdata = {16'h0, q.irms};
				`STATUS_OFF: d.prdata = {23'h0, q.gate_en, fault, q.bb_s2, q.phase};
				`FOUT_OFF:   d.prdata = {16'h0, q.fout};
				`VOUT_OFF:   d.prdata = {16'h0, q.vout};
				default:     d.prdata = 32'h0000_0000;
			endcase
		end

		// Rate divider counts every tick in all phases; ramp steps clear it
		if (tick)
			d.rate_cnt = q.rate_cnt + 16'h0001;

		// Restart sequencer; any cause overrides all phases
		if (cause) begin
			d.phase = ST_BLOCK;
			d.gate_en = 1'b0;
			d.hold_cnt = 32'h0;
			d.vout = 16'h0000;
		end else begin
			unique case (q.phase)
				ST_IDLE: begin
					d.gate_en = 1'b0;
					if (q.run_req) begin
						d.phase = ST_NORMAL;
						d.fout = q.startf;
						d.vout = vmax;
						d.gate_en = 1'b1;
					end
				end
				ST_BLOCK: begin
					d.phase = ST_HOLD;
					d.hold_cnt = 32'h0;
				end
				ST_HOLD: begin
					if (tick)
						d.hold_cnt = q.hold_cnt + 32'h1;
					// Hold counted in ticks after cause clears
					if (q.hold_cnt >= q.hold) begin
						d.gate_en = 1'b1;
						d.rate_cnt = 16'h0000;
						if (q.sel == 2'd0) begin
							d.phase = ST_NORMAL;
							d.fout = q.startf;
							d.vout = vmax;
						end else begin
							d.phase = ST_VRAMP;
							d.vout = 16'h0000;
							unique case (q.sel)
								2'd1:    d.fout = q.prevf;
								2'd2:    d.fout = q.upperf;
								default: d.fout = q.setf;
							endcase
						end
					end
				end
				ST_VRAMP: begin
					// Frequency held, voltage climbs one step per period
					if (q.irms >= q.ilim) begin
						d.phase = ST_DECEL;
						d.rate_cnt = 16'h0000;
					end else if (tick && q.rate_cnt >= q.vrec) begin
						d.rate_cnt = 16'h0000;
						if (q.vout != vmax)
							d.vout = q.vout + 16'h0001;
					end
				end
				ST_DECEL: begin
					if (q.irms < q.ilim) begin
						d.phase = ST_NORMAL;
					end else if (tick && q.rate_cnt >= q.decel) begin
						d.rate_cnt = 16'h0000;
						if (q.fout != 16'h0000)
							d.fout = q.fout - 16'h0001;
						if (q.vout != 16'h0000)
							d.vout = q.vout - 16'h0001;
					end
				end
				ST_NORMAL: begin
					// Step toward target; voltage limited by the rest of the drive
					if (!q.run_req) begin
						d.phase = ST_IDLE;
						d.gate_en = 1'b0;
					end else if (tick) begin
						if (q.fout < q.setf)
							d.fout = q.fout + 16'h0001;
						else if (q.fout > q.setf)
							d.fout = q.fout - 16'h0001;
						if (q.vout != vmax)
							d.vout = q.vout + 16'h0001;
					end
					d.prevf = q.fout;
				end
				default: d.phase = ST_IDLE;
			endcase
		end
	end

	// State register
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.phase <= ST_IDLE;
			q.hold <= `HOLD_RST;
			q.decel <= `RATE_RST;
			q.vrec <= `RATE_RST;
		end else begin
			q <= d;
		end
	end
endmodule : block_and_speed_search_restart

// [logic/restart_pkg.sv]
package restart_pkg;
	typedef enum logic [5:0] {
		ST_IDLE   = 6'b000001,
		ST_BLOCK  = 6'b000010,
		ST_HOLD   = 6'b000100,
		ST_VRAMP  = 6'b001000,
		ST_DECEL  = 6'b010000,
		ST_NORMAL = 6'b100000
	} phase_e;

	typedef struct packed {
		phase_e      phase;
		logic        ena;
		logic [1:0]  sel;
		logic        run_req;
		logic [31:0] hold;
		logic [15:0] startf;
		logic [15:0] upperf;
		logic [15:0] setf;
		logic [15:0] ilim;
		logic [15:0] decel;
		logic [15:0] vrec;
		logic [15:0] irms;
		logic [15:0] prevf;
		logic [15:0] fout;
		logic [15:0] vout;
		logic [31:0] hold_cnt;
		logic [15:0] rate_cnt;
		logic [15:0] tick_cnt;
		logic        gate_en;
		logic        ua_s1;
		logic        ua_s2;
		logic        oa_s1;
		logic        oa_s2;
		logic        bb_s1;
		logic        bb_s2;
		logic [31:0] prdata;
	} state_s;
endpackage : restart_pkg

// [logic/restart_regs.svh]
// Function
// - Base-block input asserted stops power switching so the motor coasts.
// - After base-block release, stay blocked for hold time, then restart.
// - Supply-fault restart enabled: under/overvoltage alarm while running blocks switching.
// - After supply returns normal, stay blocked for hold time, then restart.
// - Restart type: 0 start freq, 1 previous, 2 upper limit, 3 set speed.
// - Restart type 0 skips the speed search, starting from start frequency.
// - Search begins at selected frequency with output voltage zero.
// - Hold frequency, raise voltage at recovery rate until current reaches limit.
// - Lower frequency and voltage at decel rate until current drops below limit.
// - On speed match, leave search and ramp normally toward target.
`ifndef RESTART_REGS_SVH
`define RESTART_REGS_SVH

`define CTRL_OFF          12'h000
`define HOLD_OFF          12'h004
`define STARTF_OFF        12'h008
`define UPPERF_OFF        12'h00c
`define SETF_OFF          12'h010
`define ILIM_OFF          12'h014
`define DECEL_OFF         12'h018
`define VREC_OFF          12'h01c
`define IRMS_OFF          12'h020
`define STATUS_OFF        12'h024
`define FOUT_OFF          12'h028
`define VOUT_OFF          12'h02c

`define CTRL_ENA_BIT      0
`define CTRL_SEL_LSB      1
`define CTRL_RUN_BIT      3
`define HOLD_RST          32'h0000_0000
`define RATE_RST          16'h0001
`define TICK_NS           1000
`define TICK_CYCLES       (`TICK_NS / 4)

`endif

// [verification/motor_model.sv]
`timescale 1ns/1ns
module motor_model (
	input  wire logic        gate_enable,
	input  wire logic [15:0] output_voltage,
	output logic      [15:0] irms
);
	// Current tracks voltage; a coasting motor draws none
	assign irms = gate_enable ? {output_voltage[11:0], 4'h0} : 16'h0;
endmodule : motor_model

// [verification/restart_checker.sv]
`timescale 1ns/1ns
module restart_checker (
	input wire logic        mclk,
	input wire logic        reset_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        digital_input_function,
	input wire logic        gate_enable,
	input wire logic [15:0] output_frequency,
	input wire logic [15:0] output_voltage,
	input wire logic [2:0]  search_phase
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Block pin passes a 2-flop sync, so allow three edges
	property p_bb; digital_input_function[*4] |-> !gate_enable && search_phase == 3'h1; endproperty
	a_bb: assert property (p_bb) else $error("block pin ignored");
	property p_hold; $fell(digital_input_function) |-> !gate_enable[*4]; endproperty
	a_hold: assert property (p_hold) else $error("released too early");
	property p_blk; search_phase == 3'h1 ##1 search_phase == 3'h1 |-> !gate_enable; endproperty
	a_blk: assert property (p_blk) else $error("gate on while blocked");
	property p_vz; $rose(search_phase == 3'h3) |-> output_voltage == 16'h0; endproperty
	a_vz: assert property (p_vz) else $error("search voltage not zero");
	property p_vr; (search_phase == 3'h3)[*2] |-> $stable(output_frequency)
		&& output_voltage >= $past(output_voltage); endproperty
	a_vr: assert property (p_vr) else $error("ramp broke");
	property p_dc; (search_phase == 3'h4)[*2] |-> output_frequency <= $past(output_frequency)
		&& output_voltage <= $past(output_voltage); endproperty
	a_dc: assert property (p_dc) else $error("decel rose");
	property p_rb; $rose(digital_input_function) && search_phase inside {3'h2, 3'h3, 3'h4}
		|-> ##[1:4] search_phase == 3'h1; endproperty
	a_rb: assert property (p_rb) else $error("no reblock");
	// Zero-wait slave; error only inside an access phase
	property p_rdy; psel && penable |-> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready low");
	property p_err; pslverr |-> psel && penable; endproperty
	a_err: assert property (p_err) else $error("stray pslverr");
	c_vd: cover property (search_phase == 3'h3 ##1 search_phase == 3'h4);
	c_dn: cover property (search_phase == 3'h4 ##1 search_phase == 3'h5);
	c_hn: cover property (search_phase == 3'h2 ##1 search_phase == 3'h5);
endmodule : restart_checker
bind block_and_speed_search_restart restart_checker i_restart_checker (.mclk, .reset_n,
	.psel, .penable, .pready, .pslverr, .digital_input_function, .gate_enable,
	.output_frequency, .output_voltage, .search_phase);

// [verification/tb_top.sv]
`timescale 1ns/1ns
`include "restart_regs.svh"
module tb_top;
	logic        mclk = 1'b0;
	logic        reset_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        bb_in = 1'b0;
	logic        uv_in = 1'b0;
	logic        ov_in = 1'b0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic        pready;
	logic        pslverr;
	logic        err;
	logic        gate;
	logic [15:0] fout;
	logic [15:0] vout;
	logic [15:0] irms;
	logic [2:0]  phase;
	int          failures = 0;
	int          compares = 0;
	int          cyc = 0;
	block_and_speed_search_restart i_block_and_speed_search_restart (.mclk, .reset_n, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.digital_input_function(bb_in), .undervoltage_alarm(uv_in), .overvoltage_alarm(ov_in),
		.gate_enable(gate), .output_frequency(fout), .output_voltage(vout),
		.search_phase(phase));
	motor_model i_motor_model (.gate_enable(gate), .output_voltage(vout), .irms(irms));
	always #2 mclk = ~mclk;
	// Hang guard, well above the expected run
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			conclude();
		end
	end
	task conclude;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// Setup then access; hold all until pready sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Measured current reaches the block only through software
	task feed;
		apb(1'b1, `IRMS_OFF, {16'h0, irms});
		@(negedge mclk);
	endtask : feed
	task pin(input int k, input logic v);
		@(posedge mclk);
		if (k == 0) bb_in <= v;
		else if (k == 1) ov_in <= v;
		else uv_in <= v;
		repeat (v ? 8 : 100) @(negedge mclk);
	endtask : pin
	task t_search(input logic [1:0] sel, input logic [15:0] f);
		apb(1'b1, `CTRL_OFF, {28'h1, sel, 1'b0});
		pin(0, 1'b1);
		chk("gate", 32'(gate), 32'h0);
		pin(0, 1'b0);
		chk("hold", 32'h2, 32'(phase));
		// Block pin again inside the hold countdown
		pin(0, 1'b1);
		chk("hold reblock", 32'h1, 32'(phase));
		pin(0, 1'b0);
		chk("hold restart", 32'h2, 32'(phase));
		while (phase === 3'h2) @(negedge mclk);
		if (sel == 2'h0) chk("start f", 32'h10, 32'(fout));
		else begin
			chk("search f", 32'(f), 32'(fout));
			chk("search v", 32'h0, 32'(vout));
			while (phase === 3'h3) feed();
			chk("ramp f", 32'(f), 32'(fout));
			while (phase === 3'h4) feed();
			chk("match f", 32'(f - 16'h1), 32'(fout));
		end
		chk("normal", 32'h5, 32'(phase));
		repeat (1500) @(negedge mclk);
		$display("search type %0d done", sel);
	endtask : t_search
	task t_fault;
		apb(1'b1, `CTRL_OFF, 32'h9);
		pin(1, 1'b1);
		chk("fault gate", 32'(gate), 32'h0);
		pin(1, 1'b0);
		chk("fault hold", 32'h2, 32'(phase));
		pin(2, 1'b1);
		chk("reblock", 32'h1, 32'(phase));
		pin(2, 1'b0);
		repeat (100) @(negedge mclk);
		chk("hold again", 32'h2, 32'(phase));
		while (phase === 3'h2) @(negedge mclk);
		chk("restart", 32'h5, 32'(phase));
		apb(1'b0, 12'h030, 32'h0);
		chk("unmapped err", 32'h1, 32'(err));
		chk("unmapped rd", 32'h0, rd);
		$display("fault test done");
	endtask : t_fault
	initial begin
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		apb(1'b0, `HOLD_OFF, 32'h0);
		chk("hold rst", `HOLD_RST, rd);
		apb(1'b1, `HOLD_OFF, 32'h2);
		apb(1'b1, `STARTF_OFF, 32'h10);
		apb(1'b1, `UPPERF_OFF, 32'h40);
		apb(1'b1, `SETF_OFF, 32'h3c);
		apb(1'b1, `ILIM_OFF, 32'h20);
		apb(1'b1, `DECEL_OFF, 32'h1);
		apb(1'b1, `VREC_OFF, 32'h1);
		t_search(2'h2, 16'h40);
		t_search(2'h3, 16'h3c);
		t_search(2'h1, 16'h3c);
		t_search(2'h0, 16'h10);
		t_fault();
		conclude();
	end
endmodule : tb_top
